// File: bench/fabric_ref_model.sv
// fabric side: four reference clocks and the core feedback route
// assumes the system clock; references move just after its edge
`timescale 1ns/100ps
`default_nettype none
module fabric_ref_model (
  input wire logic i_clk,
  input wire logic i_fbk_src,
  output logic [3:0] o_ref,
  output logic o_fbk
);
  int cnt [4];
  initial begin
    o_ref = 4'h0;
    foreach (cnt[k]) cnt[k] = 0;
  end
  // reference k has a period of 20 + 4k cycles; distinct so select shows
  always @(posedge i_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (cnt[k] >= 9 + 2 * k) begin
        cnt[k] <= 0;
        o_ref[k] <= ~o_ref[k];
      end else begin
        cnt[k] <= cnt[k] + 1;
      end
    end
  end
  assign o_fbk = i_fbk_src;
endmodule : fabric_ref_model
`default_nettype wire

// File: bench/pll_synth_chk_sva.sv
// port checker for the clock synthesizer control block
// bound to the top module; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module pll_synth_chk #(
  parameter int REF_TIMEOUT = 65535
) (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic I_PLL_HOLD_LOW,
  input wire logic O_SYNTH_OUT_0,
  input wire logic O_SYNTH_OUT_1,
  input wire logic O_SYNTH_OUT_2,
  input wire logic O_LOCKED,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [3:0] I_PSTRB,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  wire acc = I_PSEL & I_PENABLE;
  wire al = I_PADDR[1:0] == 2'h0;
  wire cfg_wr = acc & I_PWRITE & I_PSTRB[0] & al & (I_PADDR <= 8'h18);
  AST_READY: assert property (O_PREADY)
    else $error("pready low");
  AST_ERR_UNMAPPED: assert property (acc && al && I_PADDR > 8'h20 |-> O_PSLVERR)
    else $error("no error on unmapped access");
  AST_ERR_MAPPED: assert property (acc && al && I_PADDR <= 8'h20 |-> !O_PSLVERR)
    else $error("error on mapped access");
  AST_ERR_SETUP: assert property (!acc |-> !O_PSLVERR)
    else $error("error outside access phase");
  AST_RDATA_STANDS: assert property (acc |=> $stable(O_PRDATA))
    else $error("read data moved in access phase");
  AST_HOLD_UNLOCK: assert property (!I_PLL_HOLD_LOW |=> !O_LOCKED)
    else $error("locked while held");
  AST_HOLD_OUTS: assert property (!I_PLL_HOLD_LOW [*2] |=>
    !(O_SYNTH_OUT_0 | O_SYNTH_OUT_1 | O_SYNTH_OUT_2))
    else $error("output running while held");
  AST_LOCK_RISE: assert property ($rose(O_LOCKED) |->
    $past(I_PLL_HOLD_LOW, 1) && $past(I_PLL_HOLD_LOW, 2))
    else $error("lock rose straight out of hold");
  AST_CFG_UNLOCK: assert property (cfg_wr |-> ##[1:2] !O_LOCKED)
    else $error("lock kept after setting change");
endmodule : pll_synth_chk
bind pll_clock_synth_ctrl pll_synth_chk #(.REF_TIMEOUT(REF_TIMEOUT)) chk (
  .I_MCLK(I_MCLK), .I_SRST(I_SRST), .I_PLL_HOLD_LOW(I_PLL_HOLD_LOW),
  .O_SYNTH_OUT_0(O_SYNTH_OUT_0), .O_SYNTH_OUT_1(O_SYNTH_OUT_1),
  .O_SYNTH_OUT_2(O_SYNTH_OUT_2), .O_LOCKED(O_LOCKED), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PSTRB(I_PSTRB), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR));
`default_nettype wire

// File: bench/tb_pll_clock_synth_ctrl.sv
// self-checking bench for the clock synthesizer control block
// assumes the fabric model feeds references and loops output 0 back
`timescale 1ns/100ps
`default_nettype none
module tb_pll_clock_synth_ctrl;
  import pll_pkg::*;
  localparam int MV = 4;
  localparam int NV = 2;
  localparam int OV = 2;
  localparam int CV1 = 2;
  logic clk = 0, srst = 1, pll_hold_low = 0, psel = 0, penable = 0;
  logic pwrite = 0, fbk, out0, out1, out2, locked, pready, pslverr, er;
  logic [1:0] sel = 2'h0, mode;
  logic [3:0] refs, pstrb = 4'hF;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int fail_count = 0, checks_done = 0, cycles = 0, p, k;
  integer seed = 32'h5D19C490;
  fabric_ref_model fab (.i_clk(clk), .i_fbk_src(out0), .o_ref(refs),
    .o_fbk(fbk));
  pll_clock_synth_ctrl #(.REF_TIMEOUT(200)) dut (.I_MCLK(clk),
    .I_SRST(srst), .I_REF_CLOCK_IN(refs), .I_REF_SELECT(sel),
    .I_PLL_HOLD_LOW(pll_hold_low), .I_FABRIC_FEEDBACK_CLOCK(fbk),
    .O_SYNTH_OUT_0(out0), .O_SYNTH_OUT_1(out1), .O_SYNTH_OUT_2(out2),
    .O_LOCKED(locked), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr));
  initial forever #12.5 clk = ~clk;
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task check(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string s);
    apb(0, a, 32'h0);
    check(rd, exp, s);
  endtask : rdchk
  function int ref_per(int i);
    return 20 + 4 * i;
  endfunction : ref_per
  // feedback output 0 keeps C = 1; code 3 runs as internal
  function int exp_out(int refp, logic [1:0] m, int c);
    return (m != FBK_LOCAL && m != FBK_CORE) ? refp * NV * OV * c / MV
                                             : refp * NV * c / MV;
  endfunction : exp_out
  // cycles between two rises of output w; accumulator jitters by one
  task meas(input int w, output int n);
    logic pv;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin pv = w ? out1 : out0; @(posedge clk); n++; end
      while (!(pv === 1'b0 && (w ? out1 : out0) === 1'b1));
    end
  endtask : meas
  initial begin
    repeat (6) @(posedge clk);
    srst <= 0;
    rdchk(OFS_CTRL, CTRL_RST, "ctrl");
    rdchk(OFS_MULT, MULT_RST, "mult");
    rdchk(OFS_PREDIV, PREDIV_RST, "prediv");
    rdchk(OFS_POSTDIV, POSTDIV_RST, "postdiv");
    rdchk(OFS_OUTDIV0, OUTDIV_RST, "outdiv0");
    pstrb <= 4'hE;
    apb(1, OFS_MULT, 32'h55);
    pstrb <= 4'hF;
    rdchk(OFS_MULT, MULT_RST, "mult after lane 0 off");
    apb(1, 8'h40, $random(seed));
    check(er, 1'b1, "unmapped write error");
    rdchk(8'h24, 32'h0, "unmapped read");
    check(er, 1'b1, "unmapped read error");
    apb(1, OFS_STATUS, 32'hFFFFFFFF);
    rdchk(OFS_STATUS, 32'h0, "status in hold");
    apb(1, OFS_MULT, MV);
    apb(1, OFS_PREDIV, NV);
    apb(1, OFS_POSTDIV, 32'h1);
    apb(1, OFS_OUTDIV0 + OFS_OUTDIV_STEP, CV1 - 1);
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      k = $unsigned($random(seed)) % 4;
      pll_hold_low <= 0;
      @(posedge clk);
      sel <= k[1:0];
      apb(1, OFS_CTRL, {27'h0, 3'h3, mode});
      check(locked, 1'b0, "locked in hold");
      pll_hold_low <= 1;
      for (int n = 0; n < 3000 && locked !== 1'b1; n++) @(posedge clk);
      check(locked, 1'b1, "locked");
      rdchk(OFS_STATUS, 32'h3, "status locked");
      rdchk(OFS_PERIOD, NV * ref_per(k), "pfd period");
      meas(0, p);
      p = p - exp_out(ref_per(k), mode, 1);
      check(p >= -1 && p <= 1, 1'b1, "out0 period");
      meas(1, p);
      p = p - exp_out(ref_per(k), mode, CV1);
      check(p >= -1 && p <= 1, 1'b1, "out1 period");
      check(out2, 1'b0, "disabled output");
      apb(1, OFS_MULT, MV);
      repeat (2) @(posedge clk);
      check(locked, 1'b0, "lock after change");
    end
    end_of_test();
  end
endmodule : tb_pll_clock_synth_ctrl
`default_nettype wire

// File: hw/pll_clock_synth_ctrl.sv
// behavioural clock synthesizer with APB control registers
// assumes reference and feedback clocks sampled by I_MCLK,
// so no synthesized output can exceed half of I_MCLK
// Contract
// - four reference inputs, exactly one passed to pre-divider, chosen by select
// - reset input active low; low holds reset, high starts lock acquisition
// - lock output rises on lock and falls on any detected loss
// - chain is pre-divider, feedback multiplier, post-divider, output dividers
// - internal feedback: output equals reference times M over N, O and C
// - local or core feedback: output equals reference times M, Cfbk over N, C
// - three output clocks offered for the global clock network
// - each reference input may come from a pad or the core clock tree
// - one instance may take its reference from an LVDS receive buffer
// - internal feedback gives no defined phase between reference and outputs
// - local feedback aligns output phase to the reference
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module pll_clock_synth_ctrl
  import pll_pkg::*;
#(
  parameter int REF_TIMEOUT = REF_TIMEOUT_DEF
) (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  // pad, core tree or lvds receiver: all look alike here
  input wire logic [NUM_REF-1:0] I_REF_CLOCK_IN,
  input wire logic [1:0] I_REF_SELECT,
  input wire logic I_PLL_HOLD_LOW,
  input wire logic I_FABRIC_FEEDBACK_CLOCK,
  output logic O_SYNTH_OUT_0,
  output logic O_SYNTH_OUT_1,
  output logic O_SYNTH_OUT_2,
  output logic O_LOCKED,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR
);
  typedef enum logic [1:0] {ST_HOLD, ST_ACQUIRE, ST_LOCKED} lock_state_t;

  function automatic logic [8:0] at_least_one(input logic [8:0] v);
    at_least_one = (v == 9'h000) ? 9'h001 : v;
  endfunction : at_least_one

  logic [6:0] ctrl_q;
  logic [7:0] mult_q;
  logic [3:0] prediv_q;
  logic [1:0] postdiv_q;
  logic [7:0] outdiv_q [NUM_OUT];
  logic [31:0] prdata_q;
  lock_state_t state_q;
  lock_state_t state_d;
  logic ref_q;
  logic fb_q;
  logic fb_seen_q;
  logic [3:0] n_cnt_q;
  logic [15:0] per_cnt_q;
  logic [15:0] per_q;
  logic [3:0] good_q;

  // bus decode
  wire setup = I_PSEL && !I_PENABLE;
  wire access = I_PSEL && I_PENABLE;
  wire hit_ctrl = I_PADDR == OFS_CTRL;
  wire hit_mult = I_PADDR == OFS_MULT;
  wire hit_prediv = I_PADDR == OFS_PREDIV;
  wire hit_postdiv = I_PADDR == OFS_POSTDIV;
  wire hit_status = I_PADDR == OFS_STATUS;
  wire hit_period = I_PADDR == OFS_PERIOD;
  wire [NUM_OUT-1:0] hit_outdiv;
  wire hit_any = hit_ctrl || hit_mult || hit_prediv || hit_postdiv ||
                 hit_status || hit_period || (|hit_outdiv);
  wire wr_en = access && I_PWRITE && hit_any && I_PSTRB[0];
  // new divider values invalidate the current lock
  wire cfg_change = wr_en && !hit_status && !hit_period;

  // effective counter values
  wire [1:0] fbk_mode = ctrl_q[CTRL_FBK_LSB +: 2];
  wire [NUM_OUT-1:0] out_en = ctrl_q[CTRL_OUTEN_LSB +: NUM_OUT];
  wire [1:0] fbk_out = ctrl_q[CTRL_FBKOUT_LSB +: 2];
  wire fb_loop = fbk_mode == FBK_LOCAL || fbk_mode == FBK_CORE;
  wire [8:0] m_eff = at_least_one({1'b0, mult_q});
  wire [8:0] n_eff = at_least_one({5'h00, prediv_q});
  wire [3:0] o_eff = 4'h1 << postdiv_q;
  wire [8:0] cfbk = {1'b0, outdiv_q[(fbk_out < 2'(NUM_OUT)) ? fbk_out : 2'h0]}
                    + 9'h001;

  // reference path
  wire ref_level = I_REF_CLOCK_IN[I_REF_SELECT];
  wire ref_rise = ref_level && !ref_q;
  wire pfd_tick = ref_rise && ({5'h00, n_cnt_q} == n_eff - 9'h001);
  wire fb_rise = I_FABRIC_FEEDBACK_CLOCK && !fb_q;
  wire [15:0] per_diff = (per_cnt_q > per_q) ? per_cnt_q - per_q
                                             : per_q - per_cnt_q;
  wire per_match = per_diff <= PERIOD_TOL;
  wire fb_ok = (fbk_mode != FBK_CORE) || fb_seen_q;
  wire ref_lost = {16'h0000, per_cnt_q} >= 32'(REF_TIMEOUT);
  wire tick_bad = pfd_tick && (!per_match || !fb_ok);
  wire lose = ref_lost || tick_bad || cfg_change;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_HOLD: begin
        if (I_PLL_HOLD_LOW) state_d = ST_ACQUIRE;
      end
      ST_ACQUIRE: begin
        if (pfd_tick && !lose && good_q == LOCK_PFD_COUNT - 4'h1) begin
          state_d = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (lose) state_d = ST_ACQUIRE;
      end
    endcase
    if (!I_PLL_HOLD_LOW) state_d = ST_HOLD;
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      state_q <= ST_HOLD;
      ref_q <= 1'b0;
      fb_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ref_q <= ref_level;
      fb_q <= I_FABRIC_FEEDBACK_CLOCK;
    end
  end

  // pre-divider and period measurement
  always_ff @(posedge I_MCLK) begin
    if (I_SRST || state_q == ST_HOLD) begin
      n_cnt_q <= 4'h0;
      per_cnt_q <= 16'h0000;
      per_q <= 16'h0000;
      good_q <= 4'h0;
      fb_seen_q <= 1'b0;
    end else begin
      if (pfd_tick) begin
        n_cnt_q <= 4'h0;
        per_cnt_q <= 16'h0001;
        per_q <= per_cnt_q;
        fb_seen_q <= fb_rise;
      end else begin
        if (ref_rise) n_cnt_q <= n_cnt_q + 4'h1;
        if (per_cnt_q != 16'hFFFF) per_cnt_q <= per_cnt_q + 16'h0001;
        if (fb_rise) fb_seen_q <= 1'b1;
      end
      if (lose) begin
        good_q <= 4'h0;
      end else if (pfd_tick && good_q != LOCK_PFD_COUNT) begin
        good_q <= good_q + 4'h1;
      end
    end
  end

  // output dividers; tick and threshold give the frequency relations
  wire run_base = state_q != ST_HOLD && per_q != 16'h0000;
  wire align = pfd_tick && fb_loop;
  wire [31:0] incr = fb_loop ? 32'(m_eff) * 32'(cfbk) * 32'd2
                             : 32'(m_eff) * 32'd2;
  wire [NUM_OUT-1:0] synth_out;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      wire [31:0] c_eff = 32'(outdiv_q[gi]) + 32'd1;
      wire [31:0] thresh = fb_loop ? 32'(per_q) * c_eff
                                   : 32'(per_q) * 32'(o_eff) * c_eff;
      assign hit_outdiv[gi] = I_PADDR == OFS_OUTDIV0 + 8'(gi) * OFS_OUTDIV_STEP;
      pll_out_div #(.ACC_W(32)) u_div (
        .i_clk(I_MCLK),
        .i_rst(I_SRST),
        .i_run(run_base && out_en[gi]),
        .i_align(align),
        .i_incr(incr),
        .i_thresh(thresh),
        .o_clk(synth_out[gi])
      );
      always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
          outdiv_q[gi] <= OUTDIV_RST;
        end else if (wr_en && hit_outdiv[gi]) begin
          outdiv_q[gi] <= I_PWDATA[7:0];
        end
      end
    end
  endgenerate

  // register writes
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      ctrl_q <= CTRL_RST;
      mult_q <= MULT_RST;
      prediv_q <= PREDIV_RST;
      postdiv_q <= POSTDIV_RST;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_q <= I_PWDATA[6:0];
      if (hit_mult) mult_q <= I_PWDATA[7:0];
      if (hit_prediv) prediv_q <= I_PWDATA[3:0];
      if (hit_postdiv) postdiv_q <= I_PWDATA[1:0];
    end
  end

  // read data captured in setup so the access phase needs no wait
  wire [31:0] rd_mux =
    hit_ctrl ? {25'h0, ctrl_q} :
    hit_mult ? {24'h000000, mult_q} :
    hit_prediv ? {28'h0000000, prediv_q} :
    hit_postdiv ? {30'h0, postdiv_q} :
    hit_status ? {30'h0, state_q != ST_HOLD, state_q == ST_LOCKED} :
    hit_period ? {16'h0000, per_q} :
    hit_outdiv[0] ? {24'h000000, outdiv_q[0]} :
    hit_outdiv[1] ? {24'h000000, outdiv_q[1]} :
    hit_outdiv[2] ? {24'h000000, outdiv_q[2]} : 32'h00000000;

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= I_PWRITE ? 32'h00000000 : rd_mux;
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access && !hit_any;
  assign O_LOCKED = state_q == ST_LOCKED;
  assign O_SYNTH_OUT_0 = synth_out[0];
  assign O_SYNTH_OUT_1 = synth_out[1];
  assign O_SYNTH_OUT_2 = synth_out[2];
endmodule : pll_clock_synth_ctrl
`default_nettype wire

// File: hw/pll_out_div.sv
// one output divider channel of the synthesizer
// assumes increment and threshold are stable while running
`timescale 1ns/100ps
`default_nettype none
module pll_out_div #(
  parameter int ACC_W = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_align,
  input wire logic [ACC_W-1:0] i_incr,
  input wire logic [ACC_W-1:0] i_thresh,
  output logic o_clk
);
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic out_q;
  logic out_d;
  logic [ACC_W:0] sum;
  logic wrap;

  assign sum = {1'b0, acc_q} + {1'b0, i_incr};
  assign wrap = sum >= {1'b0, i_thresh};

  always_comb begin
    acc_d = acc_q;
    out_d = out_q;
    if (!i_run || i_thresh == '0) begin
      acc_d = '0;
      out_d = 1'b0;
    end else if (i_align) begin
      // phase restart on the reference tick
      acc_d = '0;
      out_d = 1'b1;
    end else if (wrap) begin
      acc_d = ACC_W'(sum - {1'b0, i_thresh});
      out_d = ~out_q;
    end else begin
      acc_d = sum[ACC_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_q <= '0;
      out_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      out_q <= out_d;
    end
  end

  assign o_clk = out_q;
endmodule : pll_out_div
`default_nettype wire

// File: hw/pll_pkg.sv
// constants for the clock synthesizer control block
// assumes a 40 MHz system clock and an APB register port
package pll_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MULT = 8'h04;
  localparam logic [7:0] OFS_PREDIV = 8'h08;
  localparam logic [7:0] OFS_POSTDIV = 8'h0C;
  localparam logic [7:0] OFS_OUTDIV0 = 8'h10;
  localparam logic [7:0] OFS_OUTDIV_STEP = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_PERIOD = 8'h20;
  // control field positions
  localparam int CTRL_FBK_LSB = 0;
  localparam int CTRL_OUTEN_LSB = 2;
  localparam int CTRL_FBKOUT_LSB = 5;
  // feedback mode codes; code 3 behaves as internal
  localparam logic [1:0] FBK_INTERNAL = 2'h0;
  localparam logic [1:0] FBK_LOCAL = 2'h1;
  localparam logic [1:0] FBK_CORE = 2'h2;
  // reset values
  localparam logic [6:0] CTRL_RST = 7'h1C;
  localparam logic [7:0] MULT_RST = 8'h01;
  localparam logic [3:0] PREDIV_RST = 4'h1;
  localparam logic [1:0] POSTDIV_RST = 2'h0;
  localparam logic [7:0] OUTDIV_RST = 8'h00;
  // lock detector
  localparam logic [3:0] LOCK_PFD_COUNT = 4'h8;
  localparam logic [15:0] PERIOD_TOL = 16'h0001;
  localparam int REF_TIMEOUT_DEF = 65535;
  localparam int NUM_OUT = 3;
  localparam int NUM_REF = 4;
endpackage : pll_pkg
